// >>> design/swmm_core.sv
module swmm_core #(
    parameter int RAM_DEPTH = 256,
    parameter int RAM_AW = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic externalFetchSelect,
    input wire logic aluUpdate,
    input wire logic aluCarry,
    input wire logic aluHalfCarry,
    input wire logic aluOverflow,
    input wire logic instrCycle,
    input wire logic [7:0] accumulator,
    input wire logic memReq,
    input wire logic memWrite,
    input wire logic memIndirect,
    input wire logic memRegister,
    input wire logic [7:0] memAddr,
    input wire logic [7:0] memWdata,
    input wire logic fetchReq,
    input wire logic pcLoad,
    input wire logic [15:0] pcLoadAddr,
    input wire logic [7:0] romData,
    input wire logic [7:0] port0In,
    output logic [7:0] memRdata_r,
    output logic memRvalid_r,
    output logic [7:0] statusWord_r,
    output logic [15:0] romAddr_r,
    output logic [7:0] fetchData_r,
    output logic fetchValid_r,
    output logic fetchBusy_r,
    output logic fetchExternal_r,
    output logic [7:0] port0Out_r,
    output logic port0Oe_r,
    output logic [7:0] port2Out_r,
    output logic addrLatchEn_r
);

    if (RAM_DEPTH != 256 || RAM_AW != 8) begin
        $error("swmm_core: data RAM must be 256 bytes with an 8-bit address");
    end

    // ==========================================================
    // Fetch source strap
    // ==========================================================
    logic onChip;
    logic strapDone;

    swmm_fetch_strap u_strap (
        .clk(clk),
        .rst(rst),
        .pinLevel(externalFetchSelect),
        .onChip_r(onChip),
        .captured_r(strapDone)
    );

    // ==========================================================
    // Status word
    // ==========================================================
    logic [7:0] statusWord_nxt;
    logic statusHit;
    logic [1:0] bankSel;

    always_comb begin
        bankSel = {statusWord_r[swmm_pkg::BANK_SELECT_MSB_BIT],
                   statusWord_r[swmm_pkg::BANK_SELECT_LSB_BIT]};
        statusHit = memReq && !memIndirect && !memRegister
            && (memAddr == swmm_pkg::STATUS_WORD_ADDR);
    end

    // A software write and an ALU update in the same cycle both land: the ALU
    // flags win, because they describe the instruction that just finished.
    always_comb begin
        statusWord_nxt = statusWord_r;
        if (statusHit && memWrite) begin
            statusWord_nxt[swmm_pkg::CARRY_FLAG_BIT:swmm_pkg::USER_FLAG_LOW_BIT] =
                memWdata[swmm_pkg::CARRY_FLAG_BIT:swmm_pkg::USER_FLAG_LOW_BIT];
        end
        if (aluUpdate) begin
            statusWord_nxt[swmm_pkg::CARRY_FLAG_BIT] = aluCarry;
            statusWord_nxt[swmm_pkg::HALF_CARRY_FLAG_BIT] = aluHalfCarry;
            statusWord_nxt[swmm_pkg::OVERFLOW_FLAG_BIT] = aluOverflow;
        end
        if (instrCycle) begin
            statusWord_nxt[swmm_pkg::PARITY_FLAG_BIT] = ^accumulator;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            statusWord_r <= swmm_pkg::STATUS_WORD_RESET;
        end else begin
            statusWord_r <= statusWord_nxt;
        end
    end

    // ==========================================================
    // Data memory decode
    // ==========================================================
    logic [7:0] ramAddr;
    logic ramSel;
    logic ramWrEn;
    logic [7:0] ramRdata;
    logic [7:0] memRdata_nxt;
    logic memRvalid_nxt;

    always_comb begin
        if (memRegister) begin
            ramAddr = {swmm_pkg::BANK_ADDR_TOP, bankSel, memAddr[2:0]};
        end else begin
            ramAddr = memAddr;
        end
        // Indirect access always lands in RAM; direct access above the split
        // goes to the special registers and leaves RAM untouched.
        ramSel = memRegister || memIndirect
            || (memAddr < swmm_pkg::SFR_BASE);
        ramWrEn = memReq && memWrite && ramSel;
    end

    swmm_data_ram #(
        .DEPTH(RAM_DEPTH),
        .AW(RAM_AW)
    ) u_ram (
        .clk(clk),
        .wrEn(ramWrEn),
        .addr(ramAddr),
        .wdata(memWdata),
        .rdata(ramRdata)
    );

    always_comb begin
        memRdata_nxt = memRdata_r;
        memRvalid_nxt = 1'b0;
        if (memReq && !memWrite) begin
            memRvalid_nxt = 1'b1;
            if (ramSel) begin
                memRdata_nxt = ramRdata;
            end else if (statusHit) begin
                memRdata_nxt = statusWord_r;
            end else begin
                memRdata_nxt = swmm_pkg::SFR_UNMAPPED_READ;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            memRdata_r <= 8'h00;
            memRvalid_r <= 1'b0;
        end else begin
            memRdata_r <= memRdata_nxt;
            memRvalid_r <= memRvalid_nxt;
        end
    end

    // ==========================================================
    // Instruction fetch
    // ==========================================================
    swmm_pkg::swmm_fetch_state_t fetchState_r;
    swmm_pkg::swmm_fetch_state_t fetchState_nxt;
    logic [15:0] pc_r;
    logic [15:0] pc_nxt;
    logic [15:0] romAddr_nxt;
    logic [7:0] fetchData_nxt;
    logic fetchValid_nxt;
    logic fetchBusy_nxt;
    logic fetchExternal_nxt;
    logic [7:0] port0Out_nxt;
    logic port0Oe_nxt;
    logic [7:0] port2Out_nxt;
    logic addrLatchEn_nxt;

    // The program counter is a full 16 bits and simply wraps, so both memories
    // see the whole range; an on-chip strap never spills to the ports.
    always_comb begin
        fetchState_nxt = fetchState_r;
        pc_nxt = pc_r;
        romAddr_nxt = romAddr_r;
        fetchData_nxt = fetchData_r;
        fetchValid_nxt = 1'b0;
        fetchExternal_nxt = fetchExternal_r;
        port0Out_nxt = port0Out_r;
        port0Oe_nxt = 1'b0;
        port2Out_nxt = port2Out_r;
        addrLatchEn_nxt = 1'b0;
        case (fetchState_r)
            swmm_pkg::FETCH_STRAP: begin
                if (strapDone) begin
                    fetchExternal_nxt = !onChip;
                    fetchState_nxt = swmm_pkg::FETCH_IDLE;
                end
            end
            swmm_pkg::FETCH_IDLE: begin
                if (pcLoad) begin
                    pc_nxt = pcLoadAddr;
                end else if (fetchReq) begin
                    pc_nxt = pc_r + swmm_pkg::FETCH_STEP;
                    if (fetchExternal_r) begin
                        port0Out_nxt = pc_r[7:0];
                        port2Out_nxt = pc_r[15:8];
                        port0Oe_nxt = 1'b1;
                        addrLatchEn_nxt = 1'b1;
                        fetchState_nxt = swmm_pkg::FETCH_EXT_ADDR;
                    end else begin
                        romAddr_nxt = pc_r;
                        fetchState_nxt = swmm_pkg::FETCH_INT_DATA;
                    end
                end
            end
            swmm_pkg::FETCH_INT_DATA: begin
                fetchData_nxt = romData;
                fetchValid_nxt = 1'b1;
                fetchState_nxt = swmm_pkg::FETCH_IDLE;
            end
            swmm_pkg::FETCH_EXT_ADDR: begin
                // Port 0 is released here so the code byte can drive it back.
                fetchState_nxt = swmm_pkg::FETCH_EXT_DATA;
            end
            swmm_pkg::FETCH_EXT_DATA: begin
                fetchData_nxt = port0In;
                fetchValid_nxt = 1'b1;
                fetchState_nxt = swmm_pkg::FETCH_IDLE;
            end
            default: begin
                fetchState_nxt = swmm_pkg::FETCH_STRAP;
            end
        endcase
        fetchBusy_nxt = (fetchState_nxt != swmm_pkg::FETCH_IDLE);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fetchState_r <= swmm_pkg::FETCH_STRAP;
            pc_r <= swmm_pkg::RESET_VECTOR;
            romAddr_r <= swmm_pkg::RESET_VECTOR;
            fetchData_r <= 8'h00;
            fetchValid_r <= 1'b0;
            fetchBusy_r <= 1'b1;
            fetchExternal_r <= 1'b0;
            port0Out_r <= 8'h00;
            port0Oe_r <= 1'b0;
            port2Out_r <= 8'h00;
            addrLatchEn_r <= 1'b0;
        end else begin
            fetchState_r <= fetchState_nxt;
            pc_r <= pc_nxt;
            romAddr_r <= romAddr_nxt;
            fetchData_r <= fetchData_nxt;
            fetchValid_r <= fetchValid_nxt;
            fetchBusy_r <= fetchBusy_nxt;
            fetchExternal_r <= fetchExternal_nxt;
            port0Out_r <= port0Out_nxt;
            port0Oe_r <= port0Oe_nxt;
            port2Out_r <= port2Out_nxt;
            addrLatchEn_r <= addrLatchEn_nxt;
        end
    end

endmodule

// >>> design/swmm_pkg.sv
// How it works
// - Carry flag, status bit 7, takes the ALU carry or borrow out of bit 7.
// - Half-carry flag, bit 6, takes the carry or borrow across bit 3.
// - Bits 5 and 1 are user flags that only software changes.
// - Bank field, bits 4 and 3, picks one of four eight-byte register banks.
// - Overflow flag, bit 2, is set on arithmetic overflow, cleared otherwise.
// - Parity flag, bit 0, follows accumulator odd-ones count every instruction cycle.
// - The status word answers at direct address D0H.
// - Fetch addresses span 0000 to FFFF hex, on-chip or off-chip.
// - Fetch pin high at reset means on-chip only; low means off-chip only.
// - Fetch pin is latched at reset and ignored afterwards.
// - Fetching starts at address 0000H after reset.
// - Off-chip fetches use Port 0 and Port 2 for address and data.
// - RAM bytes 80H to FFH are reached only indirectly.
// - RAM bytes 00H to 7FH are reached directly and indirectly.
// - Special registers sit at direct 80H to FFH, never indirectly.
// - Upper RAM and special registers are separate storage.
// - Data RAM holds 256 bytes with an eight-bit address.
// - Lowest 32 RAM bytes form four banks; bank field picks the active one.
package swmm_pkg;

    // ==========================================================
    // Status word
    // ==========================================================
    localparam logic [7:0] STATUS_WORD_ADDR = 8'hD0;
    localparam logic [7:0] STATUS_WORD_RESET = 8'h00;
    localparam int CARRY_FLAG_BIT = 7;
    localparam int HALF_CARRY_FLAG_BIT = 6;
    localparam int USER_FLAG_HIGH_BIT = 5;
    localparam int BANK_SELECT_MSB_BIT = 4;
    localparam int BANK_SELECT_LSB_BIT = 3;
    localparam int OVERFLOW_FLAG_BIT = 2;
    localparam int USER_FLAG_LOW_BIT = 1;
    localparam int PARITY_FLAG_BIT = 0;

    // ==========================================================
    // Memory map
    // ==========================================================
    localparam logic [7:0] SFR_BASE = 8'h80;
    localparam logic [15:0] RESET_VECTOR = 16'h0000;
    localparam logic [15:0] FETCH_STEP = 16'h0001;
    localparam logic [7:0] SFR_UNMAPPED_READ = 8'h00;
    localparam logic [2:0] BANK_ADDR_TOP = 3'h0;

    // ==========================================================
    // Fetch sequencer
    // ==========================================================
    typedef enum logic [4:0] {
        FETCH_STRAP = 5'b00001,
        FETCH_IDLE = 5'b00010,
        FETCH_INT_DATA = 5'b00100,
        FETCH_EXT_ADDR = 5'b01000,
        FETCH_EXT_DATA = 5'b10000
    } swmm_fetch_state_t;

endpackage

// >>> design/swmm_fetch_strap.sv
module swmm_fetch_strap (
    input wire logic clk,
    input wire logic rst,
    input wire logic pinLevel,
    output logic onChip_r,
    output logic captured_r
);

    logic onChip_nxt;
    logic captured_nxt;

    // The level flop has no asynchronous reset, because such a reset can only load
    // a constant. It follows the pin on every edge while reset is held and freezes
    // at release, so a pin that moves together with the release is not seen.
    // Reset must therefore span at least one clock edge.
    always_comb begin
        onChip_nxt = onChip_r;
        captured_nxt = captured_r;
        if (rst) begin
            onChip_nxt = pinLevel;
        end else if (!captured_r) begin
            captured_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        onChip_r <= onChip_nxt;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            captured_r <= 1'b0;
        end else begin
            captured_r <= captured_nxt;
        end
    end

endmodule

// >>> design/swmm_data_ram.sv
module swmm_data_ram #(
    parameter int DEPTH = 256,
    parameter int AW = 8
) (
    input wire logic clk,
    input wire logic wrEn,
    input wire logic [AW-1:0] addr,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata
);

    if (DEPTH != (1 << AW)) begin
        $error("swmm_data_ram: DEPTH must equal 2**AW");
    end

    logic [7:0] mem [DEPTH];

    always_comb begin
        rdata = mem[addr];
    end

    always_ff @(posedge clk) begin
        if (wrEn) begin
            mem[addr] <= wdata;
        end
    end

endmodule

// >>> sim/swmm_code_mem.sv
module swmm_code_mem (
    input wire logic clk,
    input wire logic [15:0] romAddr_r,
    input wire logic [7:0] port0Out_r,
    input wire logic port0Oe_r,
    input wire logic [7:0] port2Out_r,
    input wire logic addrLatchEn_r,
    output logic [7:0] romData,
    output logic [7:0] port0In
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] lowAddr;
    // =========================================================
    // Code store
    // =========================================================
    // Port 0 carries the low address first, so it is caught on the strobe.
    always_ff @(posedge clk) begin
        if (addrLatchEn_r) begin
            lowAddr <= port0Out_r;
        end
    end
    assign romData = romAddr_r[7:0] ^ romAddr_r[15:8] ^ 8'hA5;
    assign port0In = port0Oe_r ? port0Out_r : lowAddr ^ port2Out_r ^ 8'h5A;
endmodule

// >>> sim/swmm_core_props.sv
module swmm_core_props (
    input wire logic clk,
    input wire logic rst,
    input wire logic aluUpdate,
    input wire logic aluCarry,
    input wire logic aluHalfCarry,
    input wire logic aluOverflow,
    input wire logic instrCycle,
    input wire logic [7:0] accumulator,
    input wire logic memReq,
    input wire logic memWrite,
    input wire logic memIndirect,
    input wire logic memRegister,
    input wire logic [7:0] memAddr,
    input wire logic [7:0] memWdata,
    input wire logic fetchReq,
    input wire logic pcLoad,
    input wire logic [7:0] memRdata_r,
    input wire logic [7:0] statusWord_r,
    input wire logic fetchValid_r,
    input wire logic fetchBusy_r,
    input wire logic fetchExternal_r,
    input wire logic port0Oe_r,
    input wire logic addrLatchEn_r
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    wire logic dirAcc = memReq && !memIndirect && !memRegister;
    wire logic staWr = dirAcc && memWrite && memAddr == swmm_pkg::STATUS_WORD_ADDR;
    wire logic take = fetchReq && !fetchBusy_r && !pcLoad;
    carry_flag_a: assert property (aluUpdate |=> statusWord_r[7] == $past(aluCarry))
        else $error("carry flag wrong");
    half_carry_a: assert property (aluUpdate |=> statusWord_r[6] == $past(aluHalfCarry))
        else $error("half carry flag wrong");
    overflow_flag_a: assert property (aluUpdate |=> statusWord_r[2] == $past(aluOverflow))
        else $error("overflow flag wrong");
    parity_flag_a: assert property (instrCycle |=> statusWord_r[0] == ^$past(accumulator))
        else $error("parity flag wrong");
    user_flags_a: assert property (!staWr |=> $stable({statusWord_r[5:3], statusWord_r[1]}))
        else $error("user flags changed without write");
    status_write_a: assert property (staWr && !aluUpdate |=> statusWord_r[7:1] == $past(memWdata[7:1]))
        else $error("status write lost");
    sfr_read_a: assert property (dirAcc && !memWrite && memAddr[7] && !staWr && memAddr != 8'hD0
        |=> memRdata_r == 8'h00)
        else $error("special read not zero");
    int_fetch_a: assert property (take && !fetchExternal_r |=> fetchBusy_r ##1 fetchValid_r)
        else $error("internal fetch timing wrong");
    ext_fetch_a: assert property (take && fetchExternal_r
        |=> addrLatchEn_r && port0Oe_r ##1 !port0Oe_r ##1 fetchValid_r)
        else $error("external fetch timing wrong");
    strap_hold_a: assert property (!fetchBusy_r |=> $stable(fetchExternal_r))
        else $error("fetch source changed after reset");
    cover property (take && fetchExternal_r);
    cover property (take && !fetchExternal_r);
    cover property (staWr);
endmodule

bind swmm_core swmm_core_props u_props (.clk(clk), .rst(rst), .aluUpdate(aluUpdate),
    .aluCarry(aluCarry), .aluHalfCarry(aluHalfCarry), .aluOverflow(aluOverflow),
    .instrCycle(instrCycle), .accumulator(accumulator), .memReq(memReq), .memWrite(memWrite),
    .memIndirect(memIndirect), .memRegister(memRegister), .memAddr(memAddr),
    .memWdata(memWdata), .fetchReq(fetchReq), .pcLoad(pcLoad), .memRdata_r(memRdata_r),
    .statusWord_r(statusWord_r), .fetchValid_r(fetchValid_r), .fetchBusy_r(fetchBusy_r),
    .fetchExternal_r(fetchExternal_r), .port0Oe_r(port0Oe_r), .addrLatchEn_r(addrLatchEn_r));

// >>> sim/status_word_and_memory_map_test.sv
module status_word_and_memory_map_test;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [2:0] DRD = 3'h0, DWR = 3'h4, IRD = 3'h2, IWR = 3'h6, RWR = 3'h5, RRD = 3'h1;
    logic clk, rst, externalFetchSelect, aluUpdate, aluCarry, aluHalfCarry, aluOverflow;
    logic instrCycle, memReq, memWrite, memIndirect, memRegister, fetchReq, pcLoad;
    logic [7:0] accumulator, memAddr, memWdata, romData, port0In;
    logic [7:0] memRdata_r, statusWord_r, fetchData_r, port0Out_r, port2Out_r;
    logic [15:0] pcLoadAddr, romAddr_r;
    logic memRvalid_r, fetchValid_r, fetchBusy_r, fetchExternal_r, port0Oe_r, addrLatchEn_r;
    int errCount = 0;
    int testsRun = 0;
    swmm_core u_dut (.clk(clk), .rst(rst), .externalFetchSelect(externalFetchSelect),
        .aluUpdate(aluUpdate), .aluCarry(aluCarry), .aluHalfCarry(aluHalfCarry),
        .aluOverflow(aluOverflow), .instrCycle(instrCycle), .accumulator(accumulator),
        .memReq(memReq), .memWrite(memWrite), .memIndirect(memIndirect),
        .memRegister(memRegister), .memAddr(memAddr), .memWdata(memWdata),
        .fetchReq(fetchReq), .pcLoad(pcLoad), .pcLoadAddr(pcLoadAddr), .romData(romData),
        .port0In(port0In), .memRdata_r(memRdata_r), .memRvalid_r(memRvalid_r),
        .statusWord_r(statusWord_r), .romAddr_r(romAddr_r), .fetchData_r(fetchData_r),
        .fetchValid_r(fetchValid_r), .fetchBusy_r(fetchBusy_r),
        .fetchExternal_r(fetchExternal_r), .port0Out_r(port0Out_r), .port0Oe_r(port0Oe_r),
        .port2Out_r(port2Out_r), .addrLatchEn_r(addrLatchEn_r));
    swmm_code_mem u_mem (.clk(clk), .romAddr_r(romAddr_r), .port0Out_r(port0Out_r),
        .port0Oe_r(port0Oe_r), .port2Out_r(port2Out_r), .addrLatchEn_r(addrLatchEn_r),
        .romData(romData), .port0In(port0In));
    // =========================================================
    // Shared tasks
    // =========================================================
    function automatic logic [7:0] code(input logic [15:0] a, input logic e);
        return a[7:0] ^ a[15:8] ^ (e ? 8'h5A : 8'hA5);
    endfunction
    task automatic giveVerdict();
        if (errCount == 0 && testsRun > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        testsRun++;
        if (got !== exp) begin
            errCount++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Every access leaves one idle cycle, so read data is settled on return.
    task automatic mem(input logic [2:0] m, input logic [7:0] a, input logic [7:0] d);
        {memWrite, memIndirect, memRegister} = m;
        memAddr = a;
        memWdata = d;
        memReq = 1'b1;
        @(posedge clk);
        #2 memReq = 1'b0;
        chk(16'(memRvalid_r), 16'(!m[2]));
        @(posedge clk);
        #2;
    endtask
    task automatic rd(input logic [2:0] m, input logic [7:0] a, input logic [7:0] exp);
        mem(m, a, 8'h00);
        chk(16'(memRdata_r), 16'(exp));
    endtask
    task automatic alu(input logic [2:0] f);
        {aluCarry, aluHalfCarry, aluOverflow} = f;
        aluUpdate = 1'b1;
        @(posedge clk);
        #2 aluUpdate = 1'b0;
        @(posedge clk);
        #2;
    endtask
    task automatic fetch(input logic [15:0] a, input logic ext);
        fetchReq = 1'b1;
        @(posedge clk);
        #2 fetchReq = 1'b0;
        if (ext) begin
            chk({port2Out_r, port0Out_r}, a);
            chk(16'({addrLatchEn_r, port0Oe_r}), 16'h0003);
        end else begin
            chk(romAddr_r, a);
        end
        // The valid pulse stands for one cycle only, so it is looked at right
        // after the edge that raises it.
        repeat (ext ? 2 : 1) @(posedge clk);
        #1 chk(16'(fetchValid_r), 16'h0001);
        chk(16'(fetchData_r), 16'(code(a, ext)));
        #1;
    endtask
    // =========================================================
    // Scenarios
    // =========================================================
    task automatic t_reset(input logic strap);
        rst = 1'b1;
        externalFetchSelect = strap;
        repeat (12) @(posedge clk);
        #2 chk(16'({statusWord_r, 7'h00, fetchBusy_r}), 16'h0001);
        externalFetchSelect = !strap;
        rst = 1'b0;
        repeat (3) @(posedge clk);
        #2 chk(16'({fetchExternal_r, fetchBusy_r}), 16'({!strap, 1'b0}));
    endtask
    task automatic t_flags();
        for (int i = 0; i < 8; i++) begin
            alu(i[2:0]);
            chk(16'({statusWord_r[7:6], statusWord_r[2]}), 16'(i));
        end
    endtask
    task automatic t_parity();
        for (int i = 0; i < 4; i++) begin
            accumulator = 8'(8'h13 * i);
            instrCycle = 1'b1;
            @(posedge clk);
            #2 instrCycle = 1'b0;
            @(posedge clk);
            #2 chk(16'(statusWord_r[0]), 16'(^accumulator));
        end
        mem(DWR, 8'hD0, 8'hFE);
        chk(16'(statusWord_r), 16'({7'h7F, ^accumulator}));
        rd(DRD, 8'hD0, {7'h7F, ^accumulator});
        alu(3'h0);
        chk(16'({statusWord_r[5:3], statusWord_r[1]}), 16'h000F);
    endtask
    task automatic t_banks();
        for (int b = 0; b < 4; b++) begin
            mem(DWR, 8'hD0, 8'(b << 3));
            mem(RWR, 8'h05, 8'(8'hB0 + b));
            rd(DRD, 8'(b * 8 + 5), 8'(8'hB0 + b));
        end
        rd(RRD, 8'hFD, 8'hB3);
        rd(DRD, 8'h05, 8'hB0);
    endtask
    task automatic t_ram();
        mem(IWR, 8'h90, 8'hAA);
        mem(DWR, 8'h90, 8'h55);
        rd(DRD, 8'h90, 8'h00);
        rd(IRD, 8'h90, 8'hAA);
        mem(DWR, 8'h7F, 8'h3C);
        rd(IRD, 8'h7F, 8'h3C);
        mem(IWR, 8'hD0, 8'h77);
        chk(16'(statusWord_r[7:1]), 16'h000C);
        mem(IWR, 8'hFF, 8'h5E);
        rd(IRD, 8'hFF, 8'h5E);
        rd(IRD, 8'hD0, 8'h77);
    endtask
    task automatic t_program(input logic ext);
        fetch(16'h0000, ext);
        fetch(16'h0001, ext);
        pcLoadAddr = 16'hFFFF;
        pcLoad = 1'b1;
        @(posedge clk);
        #2 pcLoad = 1'b0;
        fetch(16'hFFFF, ext);
        fetch(16'h0000, ext);
    endtask
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        #50000;
        errCount++;
        giveVerdict();
    end
    initial begin
        {aluUpdate, aluCarry, aluHalfCarry, aluOverflow, instrCycle, memReq} = '0;
        {memWrite, memIndirect, memRegister, fetchReq, pcLoad} = '0;
        {accumulator, memAddr, memWdata, pcLoadAddr} = '0;
        t_reset(1'b1);
        t_flags();
        t_parity();
        t_banks();
        t_ram();
        t_program(1'b0);
        t_reset(1'b0);
        t_program(1'b1);
        giveVerdict();
    end
endmodule
